// *** logic/spl_consts.svh ***
`ifndef SPL_CONSTS_SVH
`define SPL_CONSTS_SVH

// ****************************************
// Widths and reset values
// ****************************************
`define SPL_WIDTH 8
`define SPL_LAST_STAGE 7
`define SPL_STAGES_CLEAR 8'h00
`define SPL_BIT_LOW 1'h0
`define SPL_BIT_HIGH 1'h1

`endif

// *** logic/spl_latch.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "spl_consts.svh"

module spl_latch (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Controller pins
   input wire spl_pkg::spl_pins_type pins,
   // Parallel pins
   output spl_pkg::spl_par_type par_out,
   // Cascade pin
   output logic cascade_out
);
   import spl_pkg::*;

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Pins cross into core_clk first; the cost is a two-cycle lag on every pin,
   // so clock pulses must be wider than one core_clk period to be seen.
   spl_pins_type pins_sync;
   logic output_enable_sync;

   spl_sync u_sync_ser (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(pins.serial_in),
      .sync_out(pins_sync.serial_in)
   );
   spl_sync u_sync_sck (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(pins.shift_clock),
      .sync_out(pins_sync.shift_clock)
   );
   spl_sync u_sync_clr (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(pins.shift_clear_n),
      .sync_out(pins_sync.shift_clear_n)
   );
   spl_sync u_sync_lck (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(pins.latch_clock),
      .sync_out(pins_sync.latch_clock)
   );
   // The enable crosses active high, so a synchroniser still in reset keeps the pins floating.
   spl_sync u_sync_oe (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(~pins.output_enable_n),
      .sync_out(output_enable_sync)
   );

   assign pins_sync.output_enable_n = ~output_enable_sync;

   // ****************************************
   // Edge detection
   // ****************************************
   logic shift_clock_prev;
   logic latch_clock_prev;
   logic next_shift_clock_prev;
   logic next_latch_clock_prev;
   logic shift_rise;
   logic latch_rise;

   always_comb begin
      next_shift_clock_prev = pins_sync.shift_clock;
      next_latch_clock_prev = pins_sync.latch_clock;
      shift_rise = pins_sync.shift_clock & ~shift_clock_prev;
      latch_rise = pins_sync.latch_clock & ~latch_clock_prev;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shift_clock_prev <= `SPL_BIT_LOW;
         latch_clock_prev <= `SPL_BIT_LOW;
      end else begin
         shift_clock_prev <= next_shift_clock_prev;
         latch_clock_prev <= next_latch_clock_prev;
      end
   end

   // ****************************************
   // Shift and storage registers
   // ****************************************
   spl_byte_type stages;
   spl_byte_type storage;
   spl_byte_type next_stages;
   spl_byte_type next_storage;

   always_comb begin
      next_stages = stages;
      next_storage = storage;
      // Both updates read the old stages, so a shared edge stores pre-shift data.
      if (latch_rise) begin
         next_storage = stages;
      end
      if (!pins_sync.shift_clear_n) begin
         next_stages = `SPL_STAGES_CLEAR;
      end else if (shift_rise) begin
         next_stages = {stages[`SPL_LAST_STAGE-1:0], pins_sync.serial_in};
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stages <= `SPL_STAGES_CLEAR;
         storage <= `SPL_STAGES_CLEAR;
      end else begin
         stages <= next_stages;
         storage <= next_storage;
      end
   end

   // ****************************************
   // Pin drive
   // ****************************************
   spl_byte_type enable_reg;
   spl_byte_type next_enable_reg;
   logic next_cascade_out;

   always_comb begin
      next_enable_reg = {`SPL_WIDTH{~pins_sync.output_enable_n}};
      next_cascade_out = next_stages[`SPL_LAST_STAGE];
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enable_reg <= `SPL_STAGES_CLEAR;
         cascade_out <= `SPL_BIT_LOW;
      end else begin
         enable_reg <= next_enable_reg;
         cascade_out <= next_cascade_out;
      end
   end

   always_comb begin
      par_out.data = storage;
      par_out.enable = enable_reg;
   end
endmodule // spl_latch

`default_nettype wire

// *** logic/spl_pkg.sv ***
`default_nettype none
`include "spl_consts.svh"

package spl_pkg;

   // ****************************************
   // Types
   // ****************************************
   typedef logic [`SPL_WIDTH-1:0] spl_byte_type;

   // Controller-side pins, all asynchronous to core_clk.
   typedef struct packed {
      logic serial_in;
      logic shift_clock;
      logic shift_clear_n;
      logic latch_clock;
      logic output_enable_n;
   } spl_pins_type;

   // Parallel pin drive: value and per-pin enable.
   typedef struct packed {
      spl_byte_type data;
      spl_byte_type enable;
   } spl_par_type;

endpackage

`default_nettype wire

// *** logic/spl_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "spl_consts.svh"

// Two-flop synchroniser for one asynchronous level.
module spl_sync (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Level
   input wire logic async_in,
   output logic sync_out
);
   logic meta;
   logic next_meta;
   logic next_sync_out;

   always_comb begin
      next_meta = async_in;
      next_sync_out = meta;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta <= `SPL_BIT_LOW;
         sync_out <= `SPL_BIT_LOW;
      end else begin
         meta <= next_meta;
         sync_out <= next_sync_out;
      end
   end
endmodule // spl_sync

`default_nettype wire

// *** tb/serial_to_parallel_latch_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_to_parallel_latch_tb_top;
   import spl_pkg::*;
   logic core_clk = 1'h0;
   logic rst = 1'h1;
   logic oe_n = 1'h1;
   spl_pins_type pins;
   spl_par_type par_out;
   logic cascade_out;
   logic [31:0] r;
   spl_byte_type stg = 8'h00;
   spl_byte_type sto = 8'h00;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   wire [7:0] q;
   always #2.5 core_clk = ~core_clk;
   for (genvar i = 0; i < 8; i++) begin : g_pin
      assign q[i] = par_out.enable[i] ? par_out.data[i] : 1'bz;
   end
   spl_ctrl DRV (.core_clk(core_clk), .pins(pins));
   spl_latch DUT (.core_clk(core_clk), .rst(rst), .pins(pins), .par_out(par_out),
      .cascade_out(cascade_out));
   function automatic logic [7:0] exq();
      return oe_n ? 8'hzz : sto;
   endfunction
   task automatic chk(input logic [7:0] g, e);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic go(input logic s, l, d, c = 1'h1);
      DRV.pulse(s, l, d, c, oe_n);
      if (!c) stg = 8'h00;
      if (l) sto = stg;
      if (s && c) stg = {stg[6:0], d};
      chk(q, exq());
      chk({7'h00, cascade_out}, {7'h00, stg[7]});
   endtask
   task automatic wrap_up;
      $display("errors=%0d compares=%0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(32'h964bd531));
      repeat (8) @(posedge core_clk);
      #1 rst = 1'h0;
      go(1'h0, 1'h0, 1'h0);
      oe_n = 1'h0;
      for (int i = 7; i >= 0; i--) go(1'h1, 1'h0, i[0] ^ i[2]);
      go(1'h0, 1'h1, 1'h0);
      chk(q, 8'h5a);
      go(1'h1, 1'h1, 1'h1);
      go(1'h1, 1'h0, 1'h1, 1'h0);
      for (int i = 0; i < 60; i++) begin
         r = $urandom;
         if (r[7:5] == 3'h0) oe_n = r[8];
         go(r[0], r[1], r[2], r[4:3] != 2'h0);
      end
      rst = 1'h1;
      repeat (2) @(posedge core_clk);
      #1 rst = 1'h0;
      stg = 8'h00;
      sto = 8'h00;
      go(1'h1, 1'h0, 1'h1);
      wrap_up();
   end
endmodule // serial_to_parallel_latch_tb_top
`default_nettype wire

// *** tb/spl_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
module spl_ctrl (
   // Clock
   input wire logic core_clk,
   // Pins
   output spl_pkg::spl_pins_type pins
);
   import spl_pkg::*;
   initial pins = 5'h05;
   // Each pulse is one 80 ns link period; serial is set 7 cycles before the rise.
   task automatic pulse(input logic s, l, d, c, o);
      @(posedge core_clk) #1;
      pins.serial_in = d;
      pins.shift_clear_n = c;
      pins.output_enable_n = o;
      repeat (7) @(posedge core_clk);
      #1;
      pins.shift_clock = s;
      pins.latch_clock = l;
      repeat (8) @(posedge core_clk);
      #1;
      pins.shift_clock = 1'h0;
      pins.latch_clock = 1'h0;
   endtask
endmodule // spl_ctrl
`default_nettype wire

// *** tb/spl_latch_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module spl_chk (
   // Watched ports
   input wire logic core_clk,
   input wire logic rst,
   input wire spl_pkg::spl_pins_type pins,
   input wire spl_pkg::spl_par_type par_out,
   input wire logic cascade_out
);
   import spl_pkg::*;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   store_src_a: assert property ($changed(par_out.data) |-> $past(pins.latch_clock, 2))
      else $error("store moved");
   tail_src_a: assert property ($changed(cascade_out) |->
      $past(pins.shift_clock, 2) || !$past(pins.shift_clear_n, 2)) else $error("tail moved");
   tail_hold_a: assert property ((!pins.shift_clock && pins.shift_clear_n) [*6] |->
      $stable(cascade_out)) else $error("tail unstable");
   store_hold_a: assert property (!pins.latch_clock [*6] |-> $stable(par_out.data))
      else $error("store unstable");
   en_equal_a: assert property (par_out.enable inside {8'h00, 8'hff})
      else $error("enable split");
   drive_on_a: assert property (!pins.output_enable_n [*6] |-> par_out.enable == 8'hff)
      else $error("not driven");
   float_a: assert property (pins.output_enable_n [*6] |-> par_out.enable == 8'h00)
      else $error("not floating");
   clear_a: assert property (!pins.shift_clear_n [*6] |-> !cascade_out)
      else $error("not cleared");
   cover property ($rose(pins.latch_clock));
   cover property ($fell(pins.output_enable_n));
   cover property ($fell(pins.shift_clear_n));
endmodule // spl_chk
bind spl_latch spl_chk CHK (.core_clk(core_clk), .rst(rst), .pins(pins),
   .par_out(par_out), .cascade_out(cascade_out));
`default_nettype wire
